// ### hdl/mdu_map.vh
`ifndef MDU_MAP_VH
`define MDU_MAP_VH
// register addresses
`define MDU_ADDR_CTRL 8'h98
`define MDU_ADDR_DATA 8'h99
// reset values
`define MDU_CTRL_RST 8'h40
`define MDU_DATA_RST 8'h00
// control field positions
`define MDU_B_MODE 7
`define MDU_B_UNUSED 6
`define MDU_B_MCE 5
`define MDU_B_REN 4
`define MDU_B_TB8 3
`define MDU_B_RB8 2
`define MDU_B_TI 1
`define MDU_B_RI 0
// reload default and counter top
`define MDU_RELOAD_RST 8'h96
`define MDU_CNT_TOP 8'hFF
// receive bit-time sampling: 16 baud-counter overflows per bit would be finer,
// here two overflows form one bit, sample on the first (mid bit)
`endif

// ### hdl/mdu_baud_cnt.v
`timescale 1ns/1ns
`include "mdu_map.vh"
// 8-bit auto-reload counter; one-cycle pulse per bit (every second overflow)
module mdu_baud_cnt (
  input wire clk_sys,
  input wire rst_n,
  input wire tick_en,
  input wire [7:0] reload,
  input wire force_reload,
  output reg half_pulse,
  output reg bit_pulse
);
  reg [7:0] cnt_r;
  reg div_r;
  // ****************************************
  // counter with forced reload and divide by two
  // ****************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      div_r <= 1'b0;
      half_pulse <= 1'b0;
      bit_pulse <= 1'b0;
    end else begin
      half_pulse <= 1'b0;
      bit_pulse <= 1'b0;
      if (force_reload) begin
        cnt_r <= reload;
        div_r <= 1'b0;
      end else if (tick_en) begin
        if (cnt_r == `MDU_CNT_TOP) begin
          cnt_r <= reload;
          div_r <= ~div_r;
          half_pulse <= ~div_r; // first overflow: middle of bit
          bit_pulse <= div_r;   // second overflow: bit boundary
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  end
endmodule // mdu_baud_cnt

// ### hdl/mdu_uart.v
`timescale 1ns/1ns
`include "mdu_map.vh"
//
// Operation
// - ninth bit one marks address byte
// - filter on: accept only ninth-bit-one frames
// - filter off: ninth bit ignored
// - 8-bit filter requires stop bit high
// - control bit 7 picks 8/9-bit
// - control bit 6 reads one, unwritable
// - control bit 4 enables receiver
// - 9-bit mode sends control bit 3
// - bit 2 captures stop/ninth bit
// - tx done after data bits
// - rx done at stop sample
// - done flags raise interrupt when enabled
// - only software clears done flags
// - data write starts transmission
// - data read returns receive latch
// - filtered frames give no flag
// - bit rate is half overflow rate
// - start edge forces receive reload
// - start, eight (9-bit mode: nine) LSB-first data, stop
// - load only when receive flag clear
module mdu_uart #(
  parameter RELOAD_DEF = `MDU_RELOAD_RST
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] baud_reload_byte,
  input wire timer_tick_en,
  input wire irq_enable,
  input wire serial_in_pin,
  output reg [7:0] reg_rdata,
  output reg serial_out_pin,
  output reg irq_req
);
  // ****************************************
  // state codes
  // ****************************************
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_START = 4'b0010;
  localparam [3:0] ST_DATA = 4'b0100;
  localparam [3:0] ST_STOP = 4'b1000;

  reg frame_width_select_r;
  reg multidrop_filter_enable_r;
  reg receiver_enable_bit_r;
  reg tx_ninth_bit_r;
  reg rx_ninth_bit_r;
  reg tx_done_flag_r;
  reg rx_done_flag_r;
  reg [7:0] rx_latch_r;
  reg [3:0] tx_st_r;
  reg [8:0] tx_shift_r;
  reg [3:0] tx_cnt_r;
  reg [3:0] rx_st_r;
  reg [8:0] rx_shift_r;
  reg [3:0] rx_cnt_r;
  reg rx_pin_d_r;
  reg tx_kick_r;
  wire tx_half;
  wire tx_bit;
  wire rx_half;
  wire rx_bit;
  wire wr_ctrl;
  wire wr_data;
  wire start_edge;
  wire tx_set;
  wire rx_set;
  wire rx_accept;
  wire rx_ninth_val;
  wire [3:0] n_bits;
  wire [7:0] ctrl_view;

  assign wr_ctrl = reg_wr && (reg_addr == `MDU_ADDR_CTRL);
  assign wr_data = reg_wr && (reg_addr == `MDU_ADDR_DATA);
  assign n_bits = frame_width_select_r ? 4'h9 : 4'h8;
  assign start_edge = (rx_st_r == ST_IDLE) && receiver_enable_bit_r && rx_pin_d_r &&
                      !serial_in_pin;

  // ****************************************
  // baud counters, transmit and receive
  // ****************************************
  // half overflow rate
  mdu_baud_cnt u_tx_baud (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick_en(timer_tick_en),
    .reload(baud_reload_byte),
    .force_reload(tx_kick_r),
    .half_pulse(tx_half),
    .bit_pulse(tx_bit)
  );
  mdu_baud_cnt u_rx_baud (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick_en(timer_tick_en),
    .reload(baud_reload_byte),
    .force_reload(start_edge),
    .half_pulse(rx_half),
    .bit_pulse(rx_bit)
  );

  // ****************************************
  // transmitter
  // ****************************************
  // done at stop start
  assign tx_set = (tx_st_r == ST_DATA) && tx_bit && (tx_cnt_r == n_bits - 4'h1);

  // shift frame out, LSB first
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_r <= ST_IDLE;
      tx_shift_r <= 9'h000;
      tx_cnt_r <= 4'h0;
      tx_kick_r <= 1'b0;
      serial_out_pin <= 1'b1;
    end else begin
      tx_kick_r <= 1'b0;
      if (wr_data) begin
        tx_shift_r <= {tx_ninth_bit_r, reg_wdata};
        tx_cnt_r <= 4'h0;
        tx_kick_r <= 1'b1;
        tx_st_r <= ST_START;
        serial_out_pin <= 1'b0;
      end else begin
        case (tx_st_r)
          ST_IDLE: begin
            serial_out_pin <= 1'b1;
          end
          ST_START: begin
            if (tx_bit) begin
              serial_out_pin <= tx_shift_r[0];
              tx_shift_r <= {1'b0, tx_shift_r[8:1]};
              tx_st_r <= ST_DATA;
            end
          end
          ST_DATA: begin
            if (tx_bit) begin
              if (tx_cnt_r == n_bits - 4'h1) begin
                serial_out_pin <= 1'b1; // stop bit
                tx_st_r <= ST_STOP;
              end else begin
                serial_out_pin <= tx_shift_r[0];
                tx_shift_r <= {1'b0, tx_shift_r[8:1]};
                tx_cnt_r <= tx_cnt_r + 4'h1;
              end
            end
          end
          ST_STOP: begin
            if (tx_bit) begin
              tx_st_r <= ST_IDLE;
            end
          end
          default: begin
            tx_st_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  assign rx_ninth_val = frame_width_select_r ? rx_shift_r[8] : serial_in_pin;
  assign rx_accept = !rx_done_flag_r &&
                     (!multidrop_filter_enable_r || rx_ninth_val);
  assign rx_set = (rx_st_r == ST_STOP) && rx_half && rx_accept;

  // sample at mid bit
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r <= ST_IDLE;
      rx_shift_r <= 9'h000;
      rx_cnt_r <= 4'h0;
      rx_pin_d_r <= 1'b1;
    end else begin
      rx_pin_d_r <= serial_in_pin;
      case (rx_st_r)
        ST_IDLE: begin
          if (start_edge) begin
            rx_st_r <= ST_START;
            rx_cnt_r <= 4'h0;
          end
        end
        ST_START: begin
          if (rx_half) begin
            rx_st_r <= serial_in_pin ? ST_IDLE : ST_DATA; // false start check
          end
        end
        ST_DATA: begin
          if (rx_half) begin
            if (frame_width_select_r) begin
              rx_shift_r <= {serial_in_pin, rx_shift_r[8:1]};
            end else begin
              rx_shift_r <= {1'b0, serial_in_pin, rx_shift_r[7:1]};
            end
            if (rx_cnt_r == n_bits - 4'h1) begin
              rx_st_r <= ST_STOP;
            end else begin
              rx_cnt_r <= rx_cnt_r + 4'h1;
            end
          end
        end
        ST_STOP: begin
          if (rx_half) begin
            rx_st_r <= ST_IDLE;
          end
        end
        default: begin
          rx_st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // control register and receive latch
  // ****************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_width_select_r <= 1'b0;
      multidrop_filter_enable_r <= 1'b0;
      receiver_enable_bit_r <= 1'b0;
      tx_ninth_bit_r <= 1'b0;
      rx_ninth_bit_r <= 1'b0;
      tx_done_flag_r <= 1'b0;
      rx_done_flag_r <= 1'b0;
      rx_latch_r <= `MDU_DATA_RST;
    end else begin
      if (wr_ctrl) begin
        frame_width_select_r <= reg_wdata[`MDU_B_MODE];
        multidrop_filter_enable_r <= reg_wdata[`MDU_B_MCE];
        receiver_enable_bit_r <= reg_wdata[`MDU_B_REN];
        tx_ninth_bit_r <= reg_wdata[`MDU_B_TB8];
        rx_ninth_bit_r <= reg_wdata[`MDU_B_RB8];
      end
      tx_done_flag_r <= tx_set | (wr_ctrl ? reg_wdata[`MDU_B_TI] : tx_done_flag_r);
      rx_done_flag_r <= rx_set | (wr_ctrl ? reg_wdata[`MDU_B_RI] : rx_done_flag_r);
      if (rx_set) begin
        rx_latch_r <= rx_shift_r[7:0];
        rx_ninth_bit_r <= rx_ninth_val;
      end
    end
  end

  assign ctrl_view = {frame_width_select_r, 1'b1, multidrop_filter_enable_r,
                      receiver_enable_bit_r, tx_ninth_bit_r, rx_ninth_bit_r,
                      tx_done_flag_r, rx_done_flag_r};

  // ****************************************
  // read port and interrupt request
  // ****************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      irq_req <= 1'b0;
    end else begin
      if (reg_rd && reg_addr == `MDU_ADDR_CTRL) begin
        reg_rdata <= ctrl_view;
      end else if (reg_rd && reg_addr == `MDU_ADDR_DATA) begin
        reg_rdata <= rx_latch_r;
      end else if (reg_rd) begin
        reg_rdata <= 8'h00;
      end
      irq_req <= irq_enable && (tx_done_flag_r || rx_done_flag_r);
    end
  end
endmodule // mdu_uart

// ### dv/mdu_uart_assertions.sv
`timescale 1ns/1ns
module mdu_uart_assertions (
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] baud_reload_byte,
  input wire timer_tick_en,
  input wire irq_enable,
  input wire serial_in_pin,
  input wire [7:0] reg_rdata,
  input wire serial_out_pin,
  input wire irq_req
);
  // ****
  // port checks
  // ****
  logic [15:0] since_r;
  logic [15:0] since_nxt;
  wire [9:0] bitc = {9'h100 - baud_reload_byte, 1'h0};
  wire tx_wr = reg_wr && reg_addr == 8'h99;
  // ticks since the last data write, saturating
  always @* begin
    since_nxt = tx_wr ? 16'h0000 : since_r + {15'h0000, timer_tick_en && since_r != 16'hFFFF};
  end
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) since_r <= 16'hFFFF;
    else since_r <= since_nxt;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  irq_mask_a:
    assert property (!irq_enable |=> !irq_req) else $error("irq while disabled");
  irq_cause_a:
    assert property ($rose(irq_req) |-> $past(irq_enable)) else $error("irq without enable");
  irq_hold_a:
    assert property (irq_req && irq_enable && !reg_wr && !$past(reg_wr) |=> irq_req)
      else $error("flag cleared by hardware");
  rd_hold_a:
    assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  rd_ctrl_a:
    assert property (reg_rd && reg_addr == 8'h98 |=> reg_rdata[6]) else $error("bit6 low");
  rd_unmapped_a:
    assert property (reg_rd && reg_addr != 8'h98 && reg_addr != 8'h99 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
  tx_start_a:
    assert property (tx_wr |=> !serial_out_pin) else $error("no start bit");
  frame_len_a:
    assert property (!serial_out_pin |-> since_r <= 12 * bitc) else $error("line low too long");
  cover property (tx_wr);
  cover property ($rose(irq_req));
  cover property (reg_rd && reg_addr == 8'h99);
endmodule // mdu_uart_assertions
bind mdu_uart mdu_uart_assertions chk (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .baud_reload_byte, .timer_tick_en, .irq_enable, .serial_in_pin, .reg_rdata,
  .serial_out_pin, .irq_req);

// ### dv/mdu_peer.sv
`timescale 1ns/1ns
module mdu_peer #(
  parameter int BIT = 32
) (
  input wire clk_sys,
  input wire go,
  input wire [8:0] tx_word,
  input wire serial_out_pin,
  output logic serial_in_pin,
  output logic [8:0] rx_word,
  output logic rx_valid
);
  // ****
  // remote station
  // ****
  logic [10:0] fr;
  initial begin
    serial_in_pin = 1'h1;
    rx_valid = 1'h0;
    rx_word = 9'h000;
  end
  always @(posedge clk_sys) begin
    if (go) begin
      fr = {1'h1, tx_word, 1'h0};
      for (int i = 0; i < 11; i++) begin
        serial_in_pin <= fr[i];
        repeat (BIT) @(posedge clk_sys);
      end
    end
  end
  // decode data lsb first then ninth
  always @(negedge serial_out_pin) begin
    repeat (BIT / 2) @(posedge clk_sys);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge clk_sys);
      rx_word[i] <= serial_out_pin;
    end
    rx_valid <= 1'h1;
    @(posedge clk_sys) rx_valid <= 1'h0;
  end
endmodule // mdu_peer

// ### dv/multidrop_uart_control_test.sv
`timescale 1ns/1ns
module multidrop_uart_control_test;
  logic clk_sys, rst_n, reg_wr, reg_rd, irq_enable, go, rd_d, rx_valid;
  logic serial_in_pin, serial_out_pin, irq_req;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, lat;
  logic [8:0] tx_word, rx_word;
  logic [8:0] expq[$];
  logic [7:0] cw[6] = '{8'h30, 8'h10, 8'hB0, 8'hB0, 8'h90, 8'h80};
  logic [7:0] ex[6] = '{8'h70, 8'h51, 8'hF0, 8'hF5, 8'hD1, 8'hC0};
  logic [7:0] tc[3] = '{8'h08, 8'h80, 8'h88};
  logic [5:0] nb = 6'h28;
  logic [2:0] tb = 3'h5;
  int n_mismatch = 0;
  int n_tests = 0;
  // host picks reload; 0xF0 keeps bit time at 32 cycles
  mdu_uart uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .baud_reload_byte(8'hF0), .timer_tick_en(1'h1),
    .irq_enable(irq_enable), .serial_in_pin(serial_in_pin), .reg_rdata(reg_rdata),
    .serial_out_pin(serial_out_pin), .irq_req(irq_req));
  mdu_peer peer (.clk_sys(clk_sys), .go(go), .tx_word(tx_word),
    .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin), .rx_word(rx_word),
    .rx_valid(rx_valid));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge clk_sys) reg_wr <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    expq.push_back({1'h0, v});
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys) reg_rd <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic send(input logic [8:0] w);
    tx_word <= w;
    go <= 1'h1;
    @(posedge clk_sys) go <= 1'h0;
    repeat (400) @(posedge clk_sys);
  endtask
  // clock and watchdog
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end
  // results: read data and decoded line frames
  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    if (rd_d || rx_valid) chk(rd_d ? {1'h0, reg_rdata} : rx_word, expq.pop_front());
  end
  // main sequence
  initial begin
    rst_n = 1'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    irq_enable = 1'h1;
    go = 1'h0;
    rd_d = 1'h0;
    tx_word = 9'h1FF;
    void'($urandom(32'hB48221E0));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    rd(8'h98, 8'h40);
    rd(8'h99, 8'h00);
    rd(8'h50, 8'h00);
    wr(8'h98, 8'hB8);
    rd(8'h98, 8'hF8);
    d = $urandom;
    lat = d;
    wr(8'h98, 8'h10);
    send({1'h1, d});
    rd(8'h98, 8'h55);
    rd(8'h99, d);
    send({1'h1, ~d});
    rd(8'h99, d);
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      irq_enable <= i[0];
      wr(8'h98, cw[i]);
      send({nb[i], d});
      rd(8'h98, ex[i]);
      if (ex[i][0]) lat = d;
      rd(8'h99, lat);
      @(negedge clk_sys);
      chk({8'h00, irq_req}, {8'h00, i[0] & ex[i][0]});
      @(posedge clk_sys);
    end
    for (int i = 0; i < 3; i++) begin
      d = $urandom;
      wr(8'h98, tc[i]);
      expq.push_back({tb[i], d});
      wr(8'h99, d);
      repeat (400) @(posedge clk_sys);
      rd(8'h98, tc[i] | 8'h42);
      @(negedge clk_sys);
      chk({8'h00, irq_req}, 9'h001);
      @(posedge clk_sys);
    end
    end_sim();
  end
endmodule // multidrop_uart_control_test
